// ==== design/lop_map.svh ====
// Purpose: register offsets, reset values and field layout of the led output state block
// Assumes: eleven led pins split over a low byte and a three-bit high byte
// Notes: definitions only
`ifndef LOP_MAP_SVH
`define LOP_MAP_SVH

// register offsets
`define LOP_ADDR_DR_LOW 8'h73
`define LOP_ADDR_DR_HIGH 8'h74
`define LOP_ADDR_POL_LOW 8'h75
`define LOP_ADDR_POL_HIGH 8'h76
`define LOP_ADDR_MIR_LOW 8'h79
`define LOP_ADDR_MIR_HIGH 8'h7a

// reset and idle values
`define LOP_RST_BYTE 8'h00
`define LOP_RST_LEDS 11'h000
`define LOP_RD_NONE 8'h00

// field layout
`define LOP_BYTE_W 8
`define LOP_NUM_LED 11
`define LOP_LOW_W 8
`define LOP_HIGH_W 3
`define LOP_HIGH_PAD 5

// led indices with special linking
`define LOP_LED8_IDX 7
`define LOP_LED9_IDX 8
`define LOP_LED10_IDX 9
`define LOP_LED11_IDX 10

`endif

// ==== design/lop_pkg.sv ====
// Purpose: shared types of the led output state block
// Assumes: lop_map.svh gives the widths
// Notes: nothing here holds state
`include "lop_map.svh"

package lop_pkg;

  // one access of the register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`LOP_BYTE_W-1:0] addr;
    logic [`LOP_BYTE_W-1:0] wdata;
  } lop_reg_req_t;

  // drive state of one pin
  typedef struct packed {
    logic level;
    logic drive_en;
  } lop_pin_t;

endpackage

// ==== design/lop_pin_cell.sv ====
// Purpose: final drive state of one led pin
// Assumes: waveform inputs come from logic on the same clock
// Notes: output is registered, updated every cycle
`include "lop_map.svh"

module lop_pin_cell (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // pin configuration
  input wire logic i_direction,
  input wire logic i_output_type,
  input wire logic i_polarity,
  // drive selection
  input wire logic i_request,
  input wire logic i_actuated_wave,
  input wire logic i_min_duty_wave,
  // pin drive
  output lop_pkg::lop_pin_t o_pin
);

  lop_pkg::lop_pin_t pin_d;
  lop_pkg::lop_pin_t pin_q;
  logic value;
  logic level;

  always_comb begin
    // minimum duty when not actuated, behaviour waveform when actuated
    value = i_request ? i_actuated_wave : i_min_duty_wave; // R4 R5 R3
    // inverted polarity turns a one into a low pin
    level = i_polarity ? value : ~value; // R17 R11 R12
    pin_d.level = level;
    // open drain only pulls low, push pull drives both levels
    pin_d.drive_en = i_output_type ? 1'b1 : ~level; // R15
    // an input pin never drives the led
    if (!i_direction) begin // R16
      pin_d.level = 1'b0;
      pin_d.drive_en = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_d; // R19
    end
  end

  assign o_pin = pin_q;

endmodule

// ==== design/lop_led_output_state.sv ====
// Purpose: drive request, polarity and duty reference registers for eleven led pins
// Assumes: an smbus front end turns bus traffic into single-byte register accesses
// Notes: pin level and enable are registered; reads answer one cycle after the request
// How it works
// R1: request bits steer a pin only when it is an output and unlinked.
// R2: request bytes hold led8..led1 and led11..led9; both reset to zero.
// R3: a set request takes its drive from output type and polarity.
// R4: request clear gives minimum duty; set gives actuated waveform.
// R5: polarity fixes the idle state; behaviour input gives the actuated waveform.
// R6: led8 and led11 cannot be linked; only their request bits drive them.
// R7: linking led10 to the grouped sensors links led9 too.
// R8: polarity bytes hold one bit per led; zero inverted; reset zero.
// R9: polarity writes copy into mirror bits unless the mirror lock is set.
// R10: a touch on a linked sensor acts exactly like a set request.
// R11: inverted polarity counts duty as low time of the pin.
// R12: non-inverted polarity counts duty as high time of the pin.
// R13: mirror bits only reach the duty engines, never the pin drive.
// R14: non-inverted peak brightness follows from the same pin inversion.
// R15: output type zero is open drain, one is push pull.
// R16: direction zero makes the pin an input that never drives.
// R17: inverted polarity drives a one low; non-inverted drives high or releases.
// R18: a set mirror bit makes duty settings relative to full scale.
// R19: pin drive is recomputed every clock from registers and touches.
`include "lop_map.svh"

module lop_led_output_state #(
  parameter int NUM_LED = `LOP_NUM_LED
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // register port
  input wire lop_pkg::lop_reg_req_t i_reg,
  output logic [`LOP_BYTE_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // pin configuration from neighbouring registers
  input wire logic [NUM_LED-1:0] i_pin_direction,
  input wire logic [NUM_LED-1:0] i_output_type,
  input wire logic i_polarity_mirror_lock,
  // sensor linking
  input wire logic [NUM_LED-1:0] i_sensor_link,
  input wire logic [NUM_LED-1:0] i_link_touch,
  // waveforms from the duty engines
  input wire logic [NUM_LED-1:0] i_actuated_wave,
  input wire logic [NUM_LED-1:0] i_min_duty_wave,
  // to the duty engines
  output logic [NUM_LED-1:0] o_led_request,
  output logic [NUM_LED-1:0] o_led_polarity,
  output logic [NUM_LED-1:0] o_duty_reference_flip,
  // led pins
  output logic [NUM_LED-1:0] o_pin_level,
  output logic [NUM_LED-1:0] o_pin_drive_en
);

  logic [NUM_LED-1:0] drive_request_q;
  logic [NUM_LED-1:0] drive_request_d;
  logic [NUM_LED-1:0] polarity_q;
  logic [NUM_LED-1:0] polarity_d;
  logic [NUM_LED-1:0] flip_q;
  logic [NUM_LED-1:0] flip_d;
  logic [`LOP_BYTE_W-1:0] rdata_q;
  logic [`LOP_BYTE_W-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [NUM_LED-1:0] linked;
  logic [NUM_LED-1:0] link_touch;
  logic [NUM_LED-1:0] request_eff;
  lop_pkg::lop_pin_t pins [NUM_LED];

  // replace the low byte of an led vector
  function automatic logic [NUM_LED-1:0] put_low(
    input logic [NUM_LED-1:0] old,
    input logic [`LOP_BYTE_W-1:0] data
  );
    logic [NUM_LED-1:0] res;
    res = old;
    res[`LOP_LOW_W-1:0] = data[`LOP_LOW_W-1:0];
    return res;
  endfunction

  // replace the high bits of an led vector; upper data bits are ignored
  function automatic logic [NUM_LED-1:0] put_high(
    input logic [NUM_LED-1:0] old,
    input logic [`LOP_BYTE_W-1:0] data
  );
    logic [NUM_LED-1:0] res;
    res = old;
    res[NUM_LED-1:`LOP_LOW_W] = data[`LOP_HIGH_W-1:0];
    return res;
  endfunction

  // low byte of an led vector for reading
  function automatic logic [`LOP_BYTE_W-1:0] get_low(input logic [NUM_LED-1:0] v);
    return v[`LOP_LOW_W-1:0];
  endfunction

  // high bits of an led vector for reading, upper bits zero
  function automatic logic [`LOP_BYTE_W-1:0] get_high(input logic [NUM_LED-1:0] v);
    return {{`LOP_HIGH_PAD{1'b0}}, v[NUM_LED-1:`LOP_LOW_W]};
  endfunction

  // register writes and reads
  always_comb begin
    drive_request_d = drive_request_q;
    polarity_d = polarity_q;
    flip_d = flip_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (i_reg.wr) begin
      unique case (i_reg.addr)
        `LOP_ADDR_DR_LOW: begin
          drive_request_d = put_low(drive_request_q, i_reg.wdata); // R2
        end
        `LOP_ADDR_DR_HIGH: begin
          drive_request_d = put_high(drive_request_q, i_reg.wdata); // R2
        end
        `LOP_ADDR_POL_LOW: begin
          polarity_d = put_low(polarity_q, i_reg.wdata); // R8
          if (!i_polarity_mirror_lock) begin
            flip_d = put_low(flip_q, i_reg.wdata); // R9
          end
        end
        `LOP_ADDR_POL_HIGH: begin
          polarity_d = put_high(polarity_q, i_reg.wdata); // R8
          if (!i_polarity_mirror_lock) begin
            flip_d = put_high(flip_q, i_reg.wdata); // R9
          end
        end
        `LOP_ADDR_MIR_LOW: begin
          flip_d = put_low(flip_q, i_reg.wdata); // R18
        end
        `LOP_ADDR_MIR_HIGH: begin
          flip_d = put_high(flip_q, i_reg.wdata); // R18
        end
        default: begin
          flip_d = flip_q;
        end
      endcase
    end
    if (i_reg.rd) begin
      rvalid_d = 1'b1;
      unique case (i_reg.addr)
        `LOP_ADDR_DR_LOW: rdata_d = get_low(drive_request_q);
        `LOP_ADDR_DR_HIGH: rdata_d = get_high(drive_request_q);
        `LOP_ADDR_POL_LOW: rdata_d = get_low(polarity_q);
        `LOP_ADDR_POL_HIGH: rdata_d = get_high(polarity_q);
        `LOP_ADDR_MIR_LOW: rdata_d = get_low(flip_q);
        `LOP_ADDR_MIR_HIGH: rdata_d = get_high(flip_q);
        default: rdata_d = `LOP_RD_NONE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      drive_request_q <= `LOP_RST_LEDS; // R2
      polarity_q <= `LOP_RST_LEDS; // R8
      flip_q <= `LOP_RST_LEDS;
      rdata_q <= `LOP_RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      drive_request_q <= drive_request_d;
      polarity_q <= polarity_d;
      flip_q <= flip_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // sensor linking and effective request
  always_comb begin
    linked = i_sensor_link;
    link_touch = i_link_touch;
    // led8 and led11 have no sensor link
    linked[`LOP_LED8_IDX] = 1'b0; // R6
    linked[`LOP_LED11_IDX] = 1'b0; // R6
    // led9 follows the grouped sensors whenever led10 is grouped
    if (i_sensor_link[`LOP_LED10_IDX]) begin // R7
      linked[`LOP_LED9_IDX] = 1'b1;
      link_touch[`LOP_LED9_IDX] = i_link_touch[`LOP_LED10_IDX];
    end
    // a linked led takes its request from the touch, else from the register
    request_eff = (linked & link_touch) | (~linked & drive_request_q); // R1 R10
  end

  // one drive cell per led pin
  for (genvar g = 0; g < NUM_LED; g++) begin : g_pin
    lop_pin_cell u_cell (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_direction(i_pin_direction[g]),
      .i_output_type(i_output_type[g]),
      .i_polarity(polarity_q[g]),
      .i_request(request_eff[g]),
      .i_actuated_wave(i_actuated_wave[g]),
      .i_min_duty_wave(i_min_duty_wave[g]),
      .o_pin(pins[g])
    );
    assign o_pin_level[g] = pins[g].level;
    assign o_pin_drive_en[g] = pins[g].drive_en;
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_led_request = request_eff;
  assign o_led_polarity = polarity_q;
  // mirror bits go to the duty engines only
  assign o_duty_reference_flip = flip_q; // R13 R14

endmodule

// ==== bench/lop_led_output_state_asserts.sv ====
// Purpose: concurrent checks on the led output state ports
// Assumes: bound to lop_led_output_state
// Notes: pin level and drive enable checks skip the first edge after reset
`include "lop_map.svh"

module lop_led_output_state_asserts #(
  parameter int NUM_LED = 11
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // watched ports
  input wire lop_pkg::lop_reg_req_t i_reg,
  input wire logic o_reg_rvalid,
  input wire logic [NUM_LED-1:0] i_pin_direction,
  input wire logic [NUM_LED-1:0] i_output_type,
  input wire logic i_polarity_mirror_lock,
  input wire logic [NUM_LED-1:0] i_sensor_link,
  input wire logic [NUM_LED-1:0] i_link_touch,
  input wire logic [NUM_LED-1:0] i_actuated_wave,
  input wire logic [NUM_LED-1:0] i_min_duty_wave,
  input wire logic [NUM_LED-1:0] o_led_request,
  input wire logic [NUM_LED-1:0] o_led_polarity,
  input wire logic [NUM_LED-1:0] o_duty_reference_flip,
  input wire logic [NUM_LED-1:0] o_pin_level,
  input wire logic [NUM_LED-1:0] o_pin_drive_en
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [NUM_LED-1:0] wave = (o_led_request & i_actuated_wave)
    | (~o_led_request & i_min_duty_wave);
  wire logic [NUM_LED-1:0] lvl = i_pin_direction & ~(o_led_polarity ^ wave);
  wire logic pol_wr = i_reg.wr && i_reg.addr == `LOP_ADDR_POL_LOW;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  rd_answer_a: assert property (i_reg.rd |=> o_reg_rvalid)
    else $error("read not answered");
  rd_cause_a: assert property (o_reg_rvalid |-> $past(i_reg.rd))
    else $error("read answer without request");
  input_pin_a: assert property ((o_pin_drive_en & ~$past(i_pin_direction)) == '0)
    else $error("input pin driven");
  drive_en_a: assert property ($past(i_resetn) |-> o_pin_drive_en ==
    ($past(i_pin_direction) & ($past(i_output_type) | ~o_pin_level)))
    else $error("drive enable wrong");
  pin_level_a: assert property ($past(i_resetn) |-> o_pin_level == $past(lvl))
    else $error("pin level wrong");
  link_req_a: assert property ((o_led_request[6:0] & i_sensor_link[6:0]) ==
    (i_link_touch[6:0] & i_sensor_link[6:0]))
    else $error("linked request wrong");
  group_link_a: assert property (i_sensor_link[9] |-> o_led_request[8] == i_link_touch[9])
    else $error("group link wrong");
  pol_write_a: assert property (pol_wr |=> o_led_polarity[7:0] == $past(i_reg.wdata))
    else $error("polarity write lost");
  mirror_copy_a: assert property (pol_wr && !i_polarity_mirror_lock |=>
    o_duty_reference_flip[7:0] == $past(i_reg.wdata))
    else $error("mirror copy lost");
  mirror_lock_a: assert property (pol_wr && i_polarity_mirror_lock |=>
    $stable(o_duty_reference_flip))
    else $error("mirror changed while locked");
endmodule

// ==== bench/lop_led_model.sv ====
// Purpose: leds with pull-ups on the eleven pins
// Assumes: an led is lit while its pin sinks current
// Notes: a released pin floats to the pull-up level
module lop_led_model (
  // pin drive from the device
  input wire logic [10:0] i_level,
  input wire logic [10:0] i_drive_en,
  // resolved pad level and lamp state
  output logic [10:0] o_pad,
  output logic [10:0] o_lit
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_pad = (i_drive_en & i_level) | ~i_drive_en;
  assign o_lit = ~o_pad;
endmodule

// ==== bench/lop_led_output_state_tb.sv ====
// Purpose: self-checking bench for the led output state block
// Assumes: 20 MHz clock, inputs driven 5 ns after each rising edge
// Notes: read answers are matched against a queue of expected bytes
module lop_led_output_state_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 0;
  logic i_resetn = 0;
  lop_pkg::lop_reg_req_t i_reg = '0;
  logic [10:0] dir = 0, ot = 0, lk = 0, t = 0, act = 0, mn = 0, dr, pl, mir = 0, rq;
  logic [10:0] req, pol, flip, lvl, en, pad;
  logic lock = 0;
  logic [7:0] rdata;
  logic rvalid;
  logic [10:0] q[$];
  int fails = 0, comparisons = 0, cyc = 0;
  lop_led_output_state dut_u (.i_clock, .i_resetn, .i_reg, .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_pin_direction(dir), .i_output_type(ot),
    .i_polarity_mirror_lock(lock), .i_sensor_link(lk), .i_link_touch(t),
    .i_actuated_wave(act), .i_min_duty_wave(mn), .o_led_request(req),
    .o_led_polarity(pol), .o_duty_reference_flip(flip), .o_pin_level(lvl),
    .o_pin_drive_en(en));
  lop_led_model led_u (.i_level(lvl), .i_drive_en(en), .o_pad(pad), .o_lit());
  task automatic chk(string nm, logic [10:0] s, logic [10:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(logic w, logic r, logic [7:0] a, logic [7:0] d, logic [10:0] e = 0);
    @(posedge i_clock);
    #5;
    i_reg = '{w, r, a, d};
    if (r) q.push_back(e);
  endtask
  function automatic logic [10:0] req_of(logic [10:0] d, logic [10:0] l, logic [10:0] tc);
    req_of = d;
    for (int i = 0; i < 11; i++) begin
      if (l[i] && i != 7 && i != 10) req_of[i] = tc[i];
    end
    if (l[9]) req_of[8] = tc[9];
  endfunction
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  always @(negedge i_clock) begin
    if (rvalid === 1'b1) begin
      if (q.size() == 0) chk("read count", 1, 0);
      else chk("read data", {3'h0, rdata}, q.pop_front());
    end
    cyc++;
    if (cyc == 2000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    logic [7:0] a, b, c, e;
    void'($urandom(32'h87f6));
    repeat (5) @(posedge i_clock);
    #5 i_resetn = 1;
    for (int k = 0; k < 8; k++) acc(0, 1, 8'h73 + 8'(k), 0);
    acc(0, 0, 0, 0);
    $display("test done: reset values");
    for (int n = 0; n < 40; n++) begin
      @(posedge i_clock);
      #5;
      {a, b, c, e} = $urandom;
      {dir, ot, lk} = 33'({$urandom, $urandom});
      {t, act, mn} = 33'({$urandom, $urandom});
      lock = 1'($urandom);
      acc(1, 0, 8'h73, a);
      acc(1, 0, 8'h74, b);
      acc(1, 0, 8'h75, c);
      acc(1, 0, 8'h76, e);
      acc(1, 1, 8'h77, a);
      dr = {b[2:0], a};
      pl = {e[2:0], c};
      if (!lock) mir = pl;
      if (lock) begin
        acc(1, 0, 8'h79, b);
        acc(1, 0, 8'h7a, a);
        mir = {a[2:0], b};
      end
      acc(0, 1, 8'h74, 0, dr[10:8]);
      acc(0, 1, 8'h76, 0, pl[10:8]);
      acc(0, 1, 8'h79, 0, mir[7:0]);
      acc(0, 1, 8'h7a, 0, mir[10:8]);
      acc(0, 0, 0, 0);
      repeat (2) @(negedge i_clock);
      rq = req_of(dr, lk, t);
      chk("request", req, rq);
      chk("polarity", pol, pl);
      chk("mirror", flip, mir);
      rq = dir & ~(pl ^ ((rq & act) | (~rq & mn)));
      chk("pin level", lvl, rq);
      chk("drive enable", en, dir & (ot | ~rq));
      chk("pad", pad, ~dir | rq);
    end
    chk("reads left", 11'(q.size()), 0);
    $display("test done: random drive");
    complete_run();
  end
endmodule
bind lop_led_output_state lop_led_output_state_asserts #(.NUM_LED(NUM_LED)) asserts_u (
  .i_clock, .i_resetn, .i_reg, .o_reg_rvalid, .i_pin_direction, .i_output_type,
  .i_polarity_mirror_lock, .i_sensor_link, .i_link_touch, .i_actuated_wave,
  .i_min_duty_wave, .o_led_request, .o_led_polarity, .o_duty_reference_flip,
  .o_pin_level, .o_pin_drive_en);
